// [rts_sequencer.sv]
/*
 * reset cause detection, power-up delay, oscillator settle count and
 * cause flags of a small microcontroller, with an Avalon-MM slave.
 * assumes all inputs synchronous to clk; the delay and settle clocks
 * arrive as one-cycle tick pulses; the core applies regs_reset.
 */
`timescale 1ns/1ps
`default_nettype none

module rts_sequencer #(
    parameter int PIN_MIN_CYC   = rts_pkg::PIN_MIN_CYC,
    parameter int BROWN_MIN_CYC = rts_pkg::BROWN_MIN_CYC,
    parameter int DELAY_TICKS   = rts_pkg::DELAY_TICKS,
    parameter int SETTLE_CYCLES = rts_pkg::SETTLE_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // register bus
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output var  logic [31:0] avs_readdata,
    output var  logic        avs_waitrequest,
    // supply monitors and reset pin
    input  wire logic        vdd_rise_detect,
    input  wire logic        brownout_detect,
    input  wire logic        external_reset_pin_n,
    output var  logic        external_reset_pin_o,
    output var  logic        external_reset_pin_oe,
    // core state and time bases
    input  wire logic        watchdog_timeout,
    input  wire logic        sleeping,
    input  wire logic        irq_wake,
    input  wire logic        powerup_tick,
    input  wire logic        clock_input_tick,
    // reset outputs
    output var  logic        chip_reset,
    output var  logic        core_hold,
    output var  logic        regs_reset,
    output var  logic        resume,
    output var  logic [2:0]  reset_cause
);

    // ****************************************************************
    // state
    // ****************************************************************
    localparam int MW = $clog2(PIN_MIN_CYC + 1);
    localparam int BW = $clog2(BROWN_MIN_CYC + 1);
    localparam int DW = $clog2(DELAY_TICKS + 1);
    localparam int SW = $clog2(SETTLE_CYCLES + 1);

    localparam logic [MW-1:0] PIN_END    = MW'(PIN_MIN_CYC);
    localparam logic [BW-1:0] BROWN_END  = BW'(BROWN_MIN_CYC);
    localparam logic [DW-1:0] DELAY_END  = DW'(DELAY_TICKS);
    localparam logic [SW-1:0] SETTLE_END = SW'(SETTLE_CYCLES);

    typedef enum logic [2:0] {
        ST_RUN,
        ST_BROWN,
        ST_DELAY,
        ST_SETTLE,
        ST_PIN
    } rts_state_t;

    typedef struct packed {
        rts_state_t          st;
        rts_pkg::rts_cause_t cause;
        logic                is_rst;
        logic [MW-1:0]       pin_cnt;
        logic                pin_low;
        logic [BW-1:0]       brown_cnt;
        logic                brown_low;
        logic [DW-1:0]       dly_cnt;
        logic [SW-1:0]       set_cnt;
        logic                timeout_flag_n;
        logic                powerdown_flag_n;
        logic                poweron_flag_n;
        logic                brownout_flag;
        logic [7:0]          cfg;
        logic [7:0]          keep;
        logic                wreq;
        logic [31:0]         rdata;
        logic                chip_reset;
        logic                core_hold;
        logic                regs_reset;
        logic                resume;
        logic                pin_oe;
    } rts_regs_t;

    rts_regs_t         s;
    rts_regs_t         next_s;
    logic              brownout_enable_cfg;
    logic              powerup_delay_enable_n;
    logic              dly_on;
    logic              settle_on;
    logic              dly_done;
    logic              set_done;
    rts_pkg::rts_osc_t osc_mode;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // timeout and powerdown flags a cause leaves behind
    function automatic logic [1:0] flag_pair(
        input rts_pkg::rts_cause_t c,
        input logic [1:0]          cur
    );
        case (c)
            rts_pkg::RTS_C_POWERON,
            rts_pkg::RTS_C_BROWNOUT:      flag_pair = 2'h3;
            rts_pkg::RTS_C_PIN_SLEEP,
            rts_pkg::RTS_C_IRQ_WAKE:      flag_pair = 2'h2;
            rts_pkg::RTS_C_WATCHDOG_RUN:  flag_pair = 2'h1;
            rts_pkg::RTS_C_WATCHDOG_WAKE: flag_pair = 2'h0;
            default:                      flag_pair = cur;
        endcase
    endfunction : flag_pair

    // first stage of a time-out sequence
    function automatic rts_state_t first_stage(
        input logic dly,
        input logic settle
    );
        if (dly) begin
            first_stage = ST_DELAY;
        end else if (settle) begin
            first_stage = ST_SETTLE;
        end else begin
            first_stage = ST_PIN;
        end
    endfunction : first_stage

    // ****************************************************************
    // configuration decode
    // ****************************************************************
    assign brownout_enable_cfg    = s.cfg[rts_pkg::BROWN_EN_BIT];
    assign powerup_delay_enable_n = s.cfg[rts_pkg::DLY_EN_N_BIT];
    assign osc_mode  = rts_pkg::rts_osc_t'(s.cfg[rts_pkg::OSC_LSB +: 2]);
    assign dly_on    = !powerup_delay_enable_n || brownout_enable_cfg;
    assign settle_on = osc_mode != rts_pkg::RTS_OSC_RCNET;
    assign dly_done  = s.dly_cnt == DELAY_END;
    assign set_done  = s.set_cnt == SETTLE_END;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        rts_pkg::rts_cause_t ev;
        logic                hit;
        ev     = rts_pkg::RTS_C_NONE;
        hit    = (avs_read || avs_write) && s.wreq;
        next_s = s;
        next_s.regs_reset = 1'b0;
        next_s.resume     = 1'b0;
        next_s.pin_oe     = 1'b0;
        next_s.wreq       = !hit;

        // bus read: data stands while waitrequest is low
        if (avs_read && s.wreq) begin
            next_s.rdata = '0;
            case (avs_address)
                rts_pkg::STATUS_OFS: begin
                    next_s.rdata[rts_pkg::TIMEOUT_BIT]   = s.timeout_flag_n;
                    next_s.rdata[rts_pkg::POWERDOWN_BIT] = s.powerdown_flag_n;
                end
                rts_pkg::POWER_OFS: begin
                    next_s.rdata[rts_pkg::PWRON_BIT]    = s.poweron_flag_n;
                    next_s.rdata[rts_pkg::BROWNOUT_BIT] = s.brownout_flag;
                end
                rts_pkg::CFG_OFS:   next_s.rdata[7:0] = s.cfg;
                rts_pkg::CAUSE_OFS: next_s.rdata[2:0] = s.cause;
                rts_pkg::KEEP_OFS:  next_s.rdata[7:0] = s.keep;
                default:            next_s.rdata = '0;
            endcase
        end

        // bus write takes effect at the edge that ends the wait
        if (avs_write && !s.wreq && avs_byteenable[0]) begin
            case (avs_address)
                rts_pkg::POWER_OFS: begin
                    next_s.poweron_flag_n = avs_writedata[rts_pkg::PWRON_BIT];
                    next_s.brownout_flag  = avs_writedata[rts_pkg::BROWNOUT_BIT];
                end
                rts_pkg::CFG_OFS:  next_s.cfg  = avs_writedata[7:0];
                rts_pkg::KEEP_OFS: next_s.keep = avs_writedata[7:0];
                default:           next_s.cfg  = s.cfg;
            endcase
        end

        // external pin filter
        if (external_reset_pin_n) begin
            next_s.pin_cnt = '0;
            next_s.pin_low = 1'b0;
        end else if (s.pin_cnt != PIN_END) begin
            next_s.pin_cnt = s.pin_cnt + 1'b1;
        end else begin
            next_s.pin_low = 1'b1;
        end

        // brown-out dip filter
        if (!brownout_enable_cfg || !brownout_detect) begin
            next_s.brown_cnt = '0;
            next_s.brown_low = 1'b0;
        end else if (s.brown_cnt != BROWN_END) begin
            next_s.brown_cnt = s.brown_cnt + 1'b1;
        end else begin
            next_s.brown_low = 1'b1;
        end

        // cause selection, power-on first
        if (vdd_rise_detect) begin
            ev = rts_pkg::RTS_C_POWERON;
        end else if (s.brown_low && s.st != ST_BROWN) begin
            ev = rts_pkg::RTS_C_BROWNOUT;
        end else if (s.st == ST_RUN) begin
            if (s.pin_low) begin
                ev = sleeping ? rts_pkg::RTS_C_PIN_SLEEP : rts_pkg::RTS_C_PIN_RUN;
            end else if (watchdog_timeout) begin
                ev = sleeping ? rts_pkg::RTS_C_WATCHDOG_WAKE : rts_pkg::RTS_C_WATCHDOG_RUN;
            end else if (irq_wake && sleeping) begin
                ev = rts_pkg::RTS_C_IRQ_WAKE;
            end
        end

        if (ev != rts_pkg::RTS_C_NONE) begin
            next_s.cause = ev;
            {next_s.timeout_flag_n, next_s.powerdown_flag_n} =
                flag_pair(ev, {s.timeout_flag_n, s.powerdown_flag_n});
            next_s.is_rst = (ev != rts_pkg::RTS_C_WATCHDOG_WAKE) &&
                            (ev != rts_pkg::RTS_C_IRQ_WAKE);
            next_s.regs_reset = next_s.is_rst;
            case (ev)
                rts_pkg::RTS_C_POWERON: begin
                    next_s.poweron_flag_n = 1'b0;
                    next_s.st = first_stage(dly_on, settle_on);
                end
                rts_pkg::RTS_C_BROWNOUT: begin
                    next_s.brownout_flag = 1'b0;
                    next_s.st = ST_BROWN;
                end
                rts_pkg::RTS_C_WATCHDOG_WAKE,
                rts_pkg::RTS_C_IRQ_WAKE: begin
                    next_s.st = first_stage(1'b0, settle_on);
                end
                default: begin
                    next_s.st = ST_PIN;
                end
            endcase
        end else begin
            case (s.st)
                ST_BROWN: begin
                    if (!brownout_detect || !brownout_enable_cfg) begin
                        next_s.st = ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (dly_done) begin
                        next_s.st = first_stage(1'b0,
                            settle_on && s.cause == rts_pkg::RTS_C_POWERON);
                    end else if (powerup_tick) begin
                        next_s.dly_cnt = s.dly_cnt + 1'b1;
                    end
                end
                ST_SETTLE: begin
                    if (set_done) begin
                        next_s.st = ST_PIN;
                    end else if (clock_input_tick) begin
                        next_s.set_cnt = s.set_cnt + 1'b1;
                    end
                end
                ST_PIN: begin
                    if (!s.pin_low) begin
                        next_s.st     = ST_RUN;
                        next_s.resume = 1'b1;
                    end
                end
                default: begin
                    next_s.st = s.st;
                end
            endcase
        end

        // counters sit at zero outside their own stage
        if (next_s.st != ST_DELAY) begin
            next_s.dly_cnt = '0;
        end
        if (next_s.st != ST_SETTLE) begin
            next_s.set_cnt = '0;
        end
        next_s.chip_reset = next_s.is_rst && next_s.st != ST_RUN;
        next_s.core_hold  = next_s.st != ST_RUN;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s                  <= '0;
            s.st               <= ST_PIN;
            s.cause            <= rts_pkg::RTS_C_POWERON;
            s.is_rst           <= 1'b1;
            s.timeout_flag_n   <= 1'b1;
            s.powerdown_flag_n <= 1'b1;
            s.cfg              <= rts_pkg::CFG_RST;
            s.keep             <= rts_pkg::KEEP_RST;
            s.wreq             <= 1'b1;
            s.chip_reset       <= 1'b1;
            s.core_hold        <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign avs_readdata          = s.rdata;
    assign avs_waitrequest       = s.wreq;
    assign external_reset_pin_o  = 1'b0;
    assign external_reset_pin_oe = s.pin_oe;
    assign chip_reset            = s.chip_reset;
    assign core_hold             = s.core_hold;
    assign regs_reset            = s.regs_reset;
    assign resume                = s.resume;
    assign reset_cause           = s.cause;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence quiet_s;
        !vdd_rise_detect && !s.brown_low;
    endsequence

    sequence fast_power_s;
        vdd_rise_detect && !dly_on && !settle_on;
    endsequence

    pin_undriven_a: assert property (!external_reset_pin_oe)
        else $error("reset pin driven");
    pin_filter_a: assert property ($rose(s.pin_low) |->
        $past(!external_reset_pin_n) && s.pin_cnt == PIN_END)
        else $error("short pin pulse accepted");
    power_flags_a: assert property (vdd_rise_detect |=>
        s.timeout_flag_n && s.powerdown_flag_n && !s.poweron_flag_n)
        else $error("power-on flags wrong");
    wake_keeps_a: assert property (!vdd_rise_detect && !s.brown_low
        && s.st == ST_RUN && !s.pin_low && watchdog_timeout && sleeping
        |=> !regs_reset && !s.timeout_flag_n && !s.powerdown_flag_n)
        else $error("watchdog wake reset registers");
    watchdog_run_a: assert property (quiet_s and (s.st == ST_RUN
        && !s.pin_low && watchdog_timeout && !sleeping)
        |=> regs_reset && !s.timeout_flag_n && s.powerdown_flag_n ##1 !regs_reset)
        else $error("watchdog reset flags wrong");
    delay_holds_a: assert property (s.st == ST_DELAY |-> chip_reset)
        else $error("released during delay");
    settle_len_a: assert property (quiet_s and (s.st == ST_SETTLE
        && !set_done) |=> s.st == ST_SETTLE)
        else $error("settle ended early");
    rc_skip_a: assert property (quiet_s and (s.st == ST_DELAY && dly_done
        && !settle_on) |=> s.st == ST_PIN)
        else $error("settle applied in rc mode");
    brown_delay_a: assert property (!vdd_rise_detect && s.st == ST_BROWN
        && !brownout_detect |=> s.st == ST_DELAY && s.dly_cnt == '0)
        else $error("delay not forced after brown-out");
    brown_restart_a: assert property (!vdd_rise_detect && s.brown_low
        && s.st == ST_DELAY |=> s.st == ST_BROWN && chip_reset && !s.brownout_flag)
        else $error("brown-out did not restart");
    fast_release_a: assert property (fast_power_s ##1 (quiet_s and
        !s.pin_low) |=> s.st == ST_RUN && !chip_reset)
        else $error("immediate release missing");
    pin_hold_a: assert property (quiet_s and (s.st == ST_PIN
        && s.pin_low) |=> s.st == ST_PIN && core_hold)
        else $error("released with pin low");

endmodule : rts_sequencer

`default_nettype wire

// [rts_pkg.sv]
/*
 * shared constants of the reset and time-out sequencer: register map,
 * field positions, reset values, reset cause codes and timing counts.
 * assumes a 125 MHz system clock and 32-bit Avalon-MM register access.
 */
`default_nettype none

package rts_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 8000;
    // shortest accepted low pulse on the external reset pin
    localparam int PIN_MIN_NS    = 2000;
    localparam int PIN_MIN_CYC   = (PIN_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // shortest supply dip that must cause a brown-out reset
    localparam int BROWN_MIN_US  = 100;
    localparam int BROWN_MIN_CYC = (BROWN_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // power-up delay, nominal 72 ms, in ticks of its own rc oscillator
    localparam int DELAY_MS      = 72;
    localparam int DELAY_TICKS   = 1024;
    // oscillator settle count, in cycles of the main clock input
    localparam int SETTLE_CYCLES = 1024;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [4:0] STATUS_OFS = 5'h00;
    localparam logic [4:0] POWER_OFS  = 5'h04;
    localparam logic [4:0] CFG_OFS    = 5'h08;
    localparam logic [4:0] CAUSE_OFS  = 5'h0c;
    localparam logic [4:0] KEEP_OFS   = 5'h10;

    localparam int TIMEOUT_BIT   = 4;
    localparam int POWERDOWN_BIT = 3;
    localparam int PWRON_BIT     = 1;
    localparam int BROWNOUT_BIT  = 0;
    localparam int DLY_EN_N_BIT  = 0;
    localparam int BROWN_EN_BIT  = 1;
    localparam int OSC_LSB       = 2;

    // delay disabled, brown-out enabled, resistor-capacitor clock
    localparam logic [7:0] CFG_RST  = 8'h0f;
    localparam logic [7:0] KEEP_RST = 8'h00;

    // ****************************************************************
    // enumerations
    // ****************************************************************
    typedef enum logic [1:0] {
        RTS_OSC_LOWPWR,
        RTS_OSC_CRYSTAL,
        RTS_OSC_FAST,
        RTS_OSC_RCNET
    } rts_osc_t;

    typedef enum logic [2:0] {
        RTS_C_NONE,
        RTS_C_POWERON,
        RTS_C_PIN_RUN,
        RTS_C_PIN_SLEEP,
        RTS_C_WATCHDOG_RUN,
        RTS_C_WATCHDOG_WAKE,
        RTS_C_BROWNOUT,
        RTS_C_IRQ_WAKE
    } rts_cause_t;

endpackage : rts_pkg

`default_nettype wire

// [rts_supply_model.sv]
/*
 * far side of the sequencer: reset pin with pull-up, brown-out detector
 * and the two free-running time-base tick trains.
 * assumes the bench commands pin and supply-dip levels at clock edges.
 */
`timescale 1ns/1ps
`default_nettype none

module rts_supply_model #(
    parameter int PU_DIV = 8
) (
    // clock
    input  wire logic clk,
    // commands from the bench
    input  wire logic pin_low_req,
    input  wire logic dip_req,
    // toward the sequencer
    output var  logic pin_n,
    output var  logic brown,
    output var  logic pu_tick,
    output var  logic osc_tick = 1'b0
);
    int div = 0;

    // pulled up when released; may stay low across the time-outs
    assign pin_n = ~pin_low_req;
    assign brown = dip_req;

    always @(posedge clk) begin
        div      <= (div == PU_DIV - 1) ? 0 : div + 1;
        pu_tick  <= (div == 0);
        osc_tick <= ~osc_tick;
    end
endmodule : rts_supply_model

`default_nettype wire

// [reset_timeout_sequencer_tb.sv]
/*
 * self-checking bench of the reset and time-out sequencer.
 * assumes rts_pkg, rts_sequencer and rts_supply_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module reset_timeout_sequencer_tb;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic        wait_r;
    logic        vdd = 1'b0;
    logic        wdog = 1'b0;
    logic        slp = 1'b0;
    logic        irq = 1'b0;
    logic        pin_low = 1'b0;
    logic        dip = 1'b0;
    logic        pin_n, brown, pu_tick, osc_tick, pin_oe, pin_o, chip_rst, hold, regs_rst, res;
    logic [2:0]  cause;
    int          error_cnt = 0;
    int          total_checks = 0;
    int          rr_cnt = 0;
    int          oe_cnt = 0;
    int          rs_cnt = 0;
    int          r0;
    int          r1;
    logic [7:0]  m_cfg [6] = '{8'h0d, 8'h0c, 8'h05, 8'h01, 8'h09, 8'h04};
    int          m_lo [6] = '{0, 20, 5, 5, 5, 28};
    int          m_hi [6] = '{3, 50, 20, 20, 20, 70};
    int          c_k [5] = '{1, 3, 3, 1, 2};
    logic        c_s [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [7:0]  c_st [5] = '{8'h08, 8'h08, 8'h10, 8'h00, 8'h10};
    int          c_c [5] = '{4, 2, 3, 5, 7};
    int          c_r [5] = '{1, 1, 1, 0, 0};

    always #4 clk = ~clk;
    always @(posedge clk) begin
        rr_cnt <= rr_cnt + int'(regs_rst === 1'b1);
        oe_cnt <= oe_cnt + int'(pin_oe !== 1'b0);
        rs_cnt <= rs_cnt + int'(res === 1'b1);
    end

    rts_supply_model sup_u (.clk(clk), .pin_low_req(pin_low), .dip_req(dip), .pin_n(pin_n),
        .brown(brown), .pu_tick(pu_tick), .osc_tick(osc_tick));

    rts_sequencer #(.PIN_MIN_CYC(3), .BROWN_MIN_CYC(4), .DELAY_TICKS(4), .SETTLE_CYCLES(4)) dut_u (
        .clk(clk), .nrst(nrst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdat), .avs_byteenable(4'h1), .avs_readdata(rdat), .avs_waitrequest(wait_r),
        .vdd_rise_detect(vdd), .brownout_detect(brown), .external_reset_pin_n(pin_n),
        .external_reset_pin_o(pin_o), .external_reset_pin_oe(pin_oe), .watchdog_timeout(wdog),
        .sleeping(slp), .irq_wake(irq), .powerup_tick(pu_tick), .clock_input_tick(osc_tick),
        .chip_reset(chip_rst), .core_hold(hold), .regs_reset(regs_rst), .resume(res), .reset_cause(cause));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            error_cnt++;
        end
    endtask : check

    task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= ~w;
        do begin
            @(posedge clk);
            n++;
        end while (wait_r !== 1'b0 && n < 50);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            finish_test;
        end else @(posedge clk);
    endtask : bus

    task rchk(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q, e);
    endtask : rchk

    task wreg(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wreg

    // one-cycle event: 0 supply rise, 1 watchdog, 2 interrupt wake
    task ev(input int k);
        vdd <= (k == 0);
        wdog <= (k == 1);
        irq <= (k == 2);
        @(posedge clk);
        vdd <= 1'b0;
        wdog <= 1'b0;
        irq <= 1'b0;
        @(posedge clk);
    endtask : ev

    task rel(input int lo, input int hi);
        int n;
        n = 0;
        // a wake holds the core without chip reset, so wait for both
        while ((chip_rst !== 1'b0 || hold !== 1'b0) && n <= hi) begin
            @(posedge clk);
            n++;
        end
        if (n > hi) begin
            error_cnt++;
            finish_test;
        end else check(32'(n >= lo), 32'h0000_0001);
    endtask : rel

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_init;
        rchk(rts_pkg::STATUS_OFS, 32'h0000_0018);
        rchk(rts_pkg::CFG_OFS, 32'h0000_000f);
        rchk(rts_pkg::KEEP_OFS, 32'h0000_0000);
        rchk(rts_pkg::CAUSE_OFS, 32'h0000_0001);
        wreg(rts_pkg::STATUS_OFS, 32'h0000_00ff);
        wreg(5'h14, 32'h0000_00ff);
        rchk(rts_pkg::STATUS_OFS, 32'h0000_0018);
        rchk(5'h14, 32'h0000_0000);
        $display("init done");
    endtask : t_init

    task t_poweron;
        for (int i = 0; i < 6; i++) begin
            wreg(rts_pkg::CFG_OFS, {24'h00_0000, m_cfg[i]});
            wreg(rts_pkg::POWER_OFS, 32'h0000_0003);
            r0 = rr_cnt;
            r1 = rs_cnt;
            ev(0);
            check({31'h0000_0000, chip_rst}, 32'h0000_0001);
            rel(m_lo[i], m_hi[i]);
            check({29'h000_0000, cause}, 32'h0000_0001);
            check(32'(rr_cnt - r0), 32'h0000_0001);
            rchk(rts_pkg::POWER_OFS, 32'h0000_0001);
            rchk(rts_pkg::STATUS_OFS, 32'h0000_0018);
            check(32'(rs_cnt - r1), 32'h0000_0001);
        end
        pin_low <= 1'b1;
        ev(0);
        cyc(120);
        check({31'h0000_0000, chip_rst}, 32'h0000_0001);
        pin_low <= 1'b0;
        rel(0, 6);
        $display("power-on done");
    endtask : t_poweron

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task t_causes;
        wreg(rts_pkg::KEEP_OFS, 32'h0000_005a);
        for (int i = 0; i < 5; i++) begin
            r0 = rr_cnt;
            r1 = rs_cnt;
            slp <= c_s[i];
            @(posedge clk);
            if (c_k[i] == 3) begin
                pin_low <= 1'b1;
                cyc(8);
                pin_low <= 1'b0;
                @(posedge clk);
            end else ev(c_k[i]);
            check({31'h0000_0000, chip_rst}, 32'(c_r[i]));
            check({31'h0000_0000, hold}, 32'h0000_0001);
            slp <= 1'b0;
            rel(0, 20);
            check(32'(rr_cnt - r0), 32'(c_r[i]));
            check({29'h000_0000, cause}, 32'(c_c[i]));
            rchk(rts_pkg::CAUSE_OFS, 32'(c_c[i]));
            rchk(rts_pkg::STATUS_OFS, {24'h00_0000, c_st[i]});
            check(32'(rs_cnt - r1), 32'h0000_0001);
        end
        r0 = rr_cnt;
        pin_low <= 1'b1;
        cyc(3);
        pin_low <= 1'b0;
        cyc(8);
        check(32'(rr_cnt - r0), 32'h0000_0000);
        $display("causes done");
    endtask : t_causes

    task t_brown;
        wreg(rts_pkg::CFG_OFS, 32'h0000_000f);
        wreg(rts_pkg::POWER_OFS, 32'h0000_0003);
        r0 = rr_cnt;
        dip <= 1'b1;
        cyc(3);
        dip <= 1'b0;
        cyc(6);
        check(32'(rr_cnt - r0), 32'h0000_0000);
        dip <= 1'b1;
        cyc(12);
        check({31'h0000_0000, chip_rst}, 32'h0000_0001);
        dip <= 1'b0;
        cyc(10);
        check({31'h0000_0000, chip_rst}, 32'h0000_0001);
        dip <= 1'b1;
        cyc(8);
        dip <= 1'b0;
        cyc(22);
        check({31'h0000_0000, chip_rst}, 32'h0000_0001);
        rel(0, 40);
        check({29'h000_0000, cause}, 32'h0000_0006);
        rchk(rts_pkg::CAUSE_OFS, 32'h0000_0006);
        rchk(rts_pkg::POWER_OFS, 32'h0000_0002);
        rchk(rts_pkg::STATUS_OFS, 32'h0000_0018);
        rchk(rts_pkg::KEEP_OFS, 32'h0000_005a);
        check(32'(oe_cnt), 32'h0000_0000);
        check({31'h0000_0000, pin_o}, 32'h0000_0000);
        $display("brown-out done");
    endtask : t_brown

    initial begin
        cyc(10);
        nrst <= 1'b1;
        @(posedge clk);
        t_init;
        t_poweron;
        t_causes;
        t_brown;
        finish_test;
    end
endmodule : reset_timeout_sequencer_tb

`default_nettype wire
